// *** src/eapc_pkg.sv ***
/*
 * Constants, register map and carrier types for the enable, alert and
 * phase-output pin control block.
 * Assumes an APB master on pclk and synchronous, debounced pin levels.
 */
package eapc_pkg;

    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_BUSADDR  = 8'h08;
    localparam logic [7:0]  ADDR_PWR_THR  = 8'h0C;
    localparam logic [7:0]  ADDR_PWR_MEAS = 8'h10;
    localparam logic [7:0]  ADDR_PHASE    = 8'h14;

    // Control field positions
    localparam int CTRL_POL_LOW   = 0;
    localparam int CTRL_OFS_EN    = 1;
    localparam int CTRL_PROT_EN   = 2;
    localparam int CTRL_PALRT_EN  = 3;
    localparam int CTRL_SPLIT     = 4;
    localparam int CTRL_ALRT_CLR  = 5;

    // Status field positions
    localparam int ST_READY    = 0;
    localparam int ST_ENABLED  = 1;
    localparam int ST_ALERT    = 2;
    localparam int ST_PALERT   = 3;
    localparam int ST_BUS_OK   = 4;
    localparam int ST_ARMED    = 5;

    localparam int ADDR_W   = 7;
    localparam int OFS_W    = 3;
    localparam int PWR_W    = 16;
    localparam int NPHASE   = 8;

    localparam logic [31:0]       CTRL_RESET   = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] BUSADDR_RST  = 7'h40;
    localparam logic [PWR_W-1:0]  PWR_THR_RST  = 16'hFFFF;
    localparam logic [31:0]       READ_ZERO    = 32'h0000_0000;

    // Management bus clock ceiling in kHz
    localparam int MGMT_MAX_KHZ = 1000;

    typedef enum logic [2:0] {
        EAPC_OFF     = 3'b001,
        EAPC_CONFIG  = 3'b010,
        EAPC_RUN     = 3'b100
    } eapc_mode_t;

    typedef struct packed {
        logic [NPHASE-1:0] out;
        logic [NPHASE-1:0] oe;
    } eapc_phase_t;

    typedef struct packed {
        logic        paddr_dummy;
        logic        mgmt_alert_oe;
        logic        power_alert_n;
        logic        regulator_ready;
        logic        bus_allow;
    } eapc_pins_t;

    typedef struct packed {
        eapc_mode_t        mode;
        logic [31:0]       ctrl;
        logic [ADDR_W-1:0] nvm_addr;
        logic [ADDR_W-1:0] eff_addr;
        logic [OFS_W-1:0]  offset;
        logic [PWR_W-1:0]  pwr_thr;
        logic [NPHASE-1:0] phase_pat;
        logic              armed;
        logic              ready;
        logic              alert;
        logic              palert;
        logic              bus_allow;
        logic              pready;
        logic [31:0]       prdata;
    } eapc_state_t;

endpackage

// *** src/eapc_top.sv ***
/*
 * Enable, alert and phase-output pin control with an APB register file.
 * Assumes all pin inputs are already synchronous to pclk.
 */
`timescale 1ns/1ps
module eapc_top (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic                             pready,
    output logic [31:0]                      prdata,
    output logic                             pslverr,
    input  wire logic                        enable_in,
    input  wire logic                        vin_present,
    input  wire logic                        vcc_present,
    input  wire logic [eapc_pkg::OFS_W-1:0]  addr_offset_setting,
    input  wire logic                        addr_offset_bus_guard,
    input  wire logic [eapc_pkg::PWR_W-1:0]  input_power,
    input  wire logic [eapc_pkg::NPHASE-1:0] phase_pwm_core,
    output logic                             regulator_ready,
    output logic                             mgmt_alert_n,
    output logic                             mgmt_alert_oe,
    output logic                             power_alert_n,
    output logic                             mgmt_bus_allow,
    output logic [eapc_pkg::ADDR_W-1:0]      mgmt_bus_addr,
    output eapc_pkg::eapc_phase_t            phase_drive_out,
    output logic                             loop_two_first_phase_drive,
    output logic                             loop_two_second_phase_drive
);
    import eapc_pkg::*;

    eapc_state_t s_reg;
    eapc_state_t s_next;

    logic en_active;
    logic supplies_ok;
    logic acc;
    logic wr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    always_comb begin
        en_active   = enable_in ^ s_reg.ctrl[CTRL_POL_LOW];
        supplies_ok = vin_present & vcc_present;
        acc         = psel & penable;
        wr          = acc & pwrite;
    end

    always_comb begin
        logic [31:0] rd;
        logic        status_now;
        rd     = READ_ZERO;
        s_next = s_reg;
        s_next.pready = acc;
        // Read data captured in setup so it stands through the access phase
        if (psel && !penable && !pwrite) begin
            if (hit(paddr, ADDR_CTRL)) begin
                rd = s_reg.ctrl;
            end else if (hit(paddr, ADDR_STATUS)) begin
                rd[ST_READY]   = s_reg.ready;
                rd[ST_ENABLED] = en_active;
                rd[ST_ALERT]   = s_reg.alert;
                rd[ST_PALERT]  = s_reg.palert;
                rd[ST_BUS_OK]  = s_reg.bus_allow;
                rd[ST_ARMED]   = s_reg.armed;
            end else if (hit(paddr, ADDR_BUSADDR)) begin
                rd[ADDR_W-1:0] = s_reg.eff_addr;
            end else if (hit(paddr, ADDR_PWR_THR)) begin
                rd[PWR_W-1:0] = s_reg.pwr_thr;
            end else if (hit(paddr, ADDR_PWR_MEAS)) begin
                rd[PWR_W-1:0] = input_power;
            end else if (hit(paddr, ADDR_PHASE)) begin
                rd[NPHASE-1:0] = s_reg.phase_pat;
            end
            s_next.prdata = rd;
        end
        if (wr) begin
            if (hit(paddr, ADDR_CTRL)) begin
                s_next.ctrl = pwdata;
                s_next.ctrl[CTRL_ALRT_CLR] = 1'b0;
            end else if (hit(paddr, ADDR_BUSADDR)) begin
                s_next.nvm_addr = pwdata[ADDR_W-1:0];
            end else if (hit(paddr, ADDR_PWR_THR)) begin
                s_next.pwr_thr = pwdata[PWR_W-1:0];
            end
        end
        // Offset taken once, then pin becomes bus gate
        case (s_reg.mode)
            EAPC_OFF: begin
                s_next.mode = EAPC_CONFIG;
            end
            EAPC_CONFIG: begin
                s_next.offset = addr_offset_setting;
                s_next.mode   = EAPC_RUN;
            end
            EAPC_RUN: begin
                s_next.mode = EAPC_RUN;
            end
            default: begin
                s_next.mode = EAPC_OFF;
            end
        endcase
        s_next.eff_addr = s_reg.ctrl[CTRL_OFS_EN]
            ? ADDR_W'(s_reg.nvm_addr + ADDR_W'(s_reg.offset))
            : s_reg.nvm_addr;
        s_next.bus_allow = (s_reg.mode == EAPC_RUN) &&
            (!s_reg.ctrl[CTRL_PROT_EN] || addr_offset_bus_guard);
        s_next.ready = en_active && supplies_ok
                       && (s_reg.mode == EAPC_RUN);
        if (en_active && supplies_ok) begin
            s_next.armed = 1'b1;
        end
        s_next.phase_pat = phase_pwm_core;
        s_next.palert = s_reg.ctrl[CTRL_PALRT_EN]
                        && (input_power > s_reg.pwr_thr);
        status_now = (s_next.ready != s_reg.ready)
                     || (s_next.palert != s_reg.palert);
        if (wr && hit(paddr, ADDR_CTRL) && pwdata[CTRL_ALRT_CLR]) begin
            s_next.alert = 1'b0;
        end
        if (status_now) begin
            s_next.alert = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg           <= '0;
            s_reg.mode      <= EAPC_OFF;
            s_reg.ctrl      <= CTRL_RESET;
            s_reg.nvm_addr  <= BUSADDR_RST;
            s_reg.eff_addr  <= BUSADDR_RST;
            s_reg.pwr_thr   <= PWR_THR_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pready          = 1'b1;
    assign pslverr         = 1'b0;
    assign prdata          = s_reg.prdata;
    assign regulator_ready = s_reg.ready;
    assign mgmt_alert_n    = 1'b0;
    assign mgmt_alert_oe   = s_reg.alert;
    assign power_alert_n   = ~s_reg.palert;
    assign mgmt_bus_allow  = s_reg.bus_allow;
    assign mgmt_bus_addr   = s_reg.eff_addr;

    // Outputs live only while running, tri-stated until first enable with both supplies present
    genvar g;
    generate
        for (g = 0; g < NPHASE; g++) begin : g_ph
            assign phase_drive_out.out[g] = s_reg.phase_pat[g] & s_reg.ready;
            assign phase_drive_out.oe[g]  = s_reg.armed;
        end
    endgenerate

    assign loop_two_first_phase_drive  =
        s_reg.ctrl[CTRL_SPLIT] & phase_drive_out.out[NPHASE-1];
    assign loop_two_second_phase_drive =
        s_reg.ctrl[CTRL_SPLIT] & phase_drive_out.out[NPHASE-2];

    tri_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !s_reg.armed |-> phase_drive_out.oe == '0)
        else $error("phase outputs driven before enable");
    ready_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        !en_active |=> !regulator_ready)
        else $error("ready stayed high after disable");
    supply_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(vin_present && vcc_present) |=> !regulator_ready)
        else $error("ready without supplies");
    pol_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.mode == EAPC_RUN && supplies_ok &&
         (enable_in != s_reg.ctrl[CTRL_POL_LOW]) &&
         $stable(s_reg.ctrl)) |=> regulator_ready)
        else $error("enable polarity ignored");
    ofs_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.mode == EAPC_RUN |=> $stable(s_reg.offset))
        else $error("offset changed after capture");
    bus_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.mode == EAPC_RUN && s_reg.ctrl[CTRL_PROT_EN] &&
         !addr_offset_bus_guard) |=> !mgmt_bus_allow)
        else $error("bus open while guard low");
    palert_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.ctrl[CTRL_PALRT_EN] && input_power > s_reg.pwr_thr)
        |=> !power_alert_n)
        else $error("power alert missing");
    alert_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(regulator_ready) |-> mgmt_alert_oe)
        else $error("status change not flagged");
    split_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.ctrl[CTRL_SPLIT] |-> loop_two_first_phase_drive
        == phase_drive_out.out[NPHASE-1])
        else $error("loop two mapping wrong");
    split_second_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.ctrl[CTRL_SPLIT] |-> loop_two_second_phase_drive
        == phase_drive_out.out[NPHASE-2])
        else $error("loop two second mapping wrong");
    split_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !s_reg.ctrl[CTRL_SPLIT] |->
        !(loop_two_first_phase_drive || loop_two_second_phase_drive))
        else $error("loop two outputs live without split");
    oe_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.armed |=> (phase_drive_out.oe == '1))
        else $error("phase outputs released after enable");
    out_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !regulator_ready |-> (phase_drive_out.out == '0))
        else $error("phase driven while not ready");
    alert_od_a: assert property (@(posedge pclk) disable iff (!presetn)
        mgmt_alert_oe |-> !mgmt_alert_n)
        else $error("alert driven high");
    rd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable) |=> $stable(prdata))
        else $error("read data moved after access");

endmodule

// *** testbench/eapc_gate_drv.sv ***
/* Gate driver inputs and the pulled-up alert line at the pin side.
   Assumes the phase struct and alert enable come straight from the top. */
`timescale 1ns/1ps
module eapc_gate_drv
    import eapc_pkg::*;
(
    input  wire logic                        pclk,
    input  wire eapc_pkg::eapc_phase_t       phase_drive_out,
    input  wire logic                        mgmt_alert_n,
    input  wire logic                        mgmt_alert_oe,
    output logic [eapc_pkg::NPHASE-1:0]      phase_pin,
    output logic                             alert_pin
);
    logic wobble = 1'b0;
    // Floating driver inputs wander every cycle
    always @(posedge pclk) wobble <= ~wobble;
    always_comb begin
        for (int i = 0; i < NPHASE; i++) begin
            phase_pin[i] = phase_drive_out.oe[i] ? phase_drive_out.out[i]
                                                 : wobble ^ i[0];
        end
    end
    // External pull-up on the open-drain alert
    assign alert_pin = mgmt_alert_oe ? mgmt_alert_n : 1'b1;
endmodule

// *** testbench/enable_alert_pin_control_tb_top.sv ***
/* Directed bench for the pin control block over APB.
   Assumes APB read data standing in the access phase. */
`timescale 1ns/1ps
module enable_alert_pin_control_tb_top;
    import eapc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, cw = 0, d;
    logic pready, pslverr, enable_in = 0, vin_present = 0, vcc_present = 1;
    logic [OFS_W-1:0] ofs = 3'h5;
    logic guard = 0, ready, alert_n, alert_oe, palert_n, allow, l2a, l2b;
    logic [PWR_W-1:0] pwr = 0;
    logic [NPHASE-1:0] core = 0, pins;
    logic [ADDR_W-1:0] baddr;
    logic alert_pin;
    eapc_phase_t ph;
    int n_fail = 0, n_tests = 0;
    always #5 pclk = ~pclk;
    eapc_top eapc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .enable_in(enable_in), .vin_present(vin_present),
        .vcc_present(vcc_present), .addr_offset_setting(ofs),
        .addr_offset_bus_guard(guard), .input_power(pwr),
        .phase_pwm_core(core), .regulator_ready(ready),
        .mgmt_alert_n(alert_n), .mgmt_alert_oe(alert_oe),
        .power_alert_n(palert_n), .mgmt_bus_allow(allow),
        .mgmt_bus_addr(baddr), .phase_drive_out(ph),
        .loop_two_first_phase_drive(l2a),
        .loop_two_second_phase_drive(l2b));
    eapc_gate_drv eapc_gate_drv_i (.pclk(pclk), .phase_drive_out(ph),
        .mgmt_alert_n(alert_n), .mgmt_alert_oe(alert_oe),
        .phase_pin(pins), .alert_pin(alert_pin));
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        #1 n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        d = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic ctrl(input int b, input logic v);
        cw[b] = v;
        apb(1, ADDR_CTRL, cw);
        tick(2);
    endtask
    task automatic t_reset_offset;
        chk("oe", ph.oe, 0);
        chk("ready", ready, 0);
        chk("addr", baddr, BUSADDR_RST);
        ctrl(CTRL_OFS_EN, 1);
        chk("addr_ofs", baddr, 7'h45);
        ofs <= 3'h2;
        tick(3);
        chk("addr_hold", baddr, 7'h45);
    endtask
    task automatic t_enable;
        enable_in <= 1;
        tick(3);
        chk("no_vin", ready, 0);
        chk("oe_off", ph.oe, 0);
        vin_present <= 1;
        tick(3);
        chk("ready_up", ready, 1);
        chk("oe_on", ph.oe, 8'hFF);
        chk("alert_pin", alert_pin, 0);
        ctrl(CTRL_ALRT_CLR, 1);
        cw[CTRL_ALRT_CLR] = 0;
        chk("alert_clr", alert_pin, 1);
        enable_in <= 0;
        tick(3);
        chk("ready_dn", ready, 0);
        chk("phase_dn", pins & ph.oe, 0);
        ctrl(CTRL_POL_LOW, 1);
        chk("pol_low", ready, 1);
    endtask
    task automatic t_guard_power;
        ctrl(CTRL_PROT_EN, 1);
        chk("blocked", allow, 0);
        guard <= 1;
        tick(2);
        chk("allowed", allow, 1);
        apb(1, ADDR_PWR_THR, 32'h0000_1000);
        pwr <= 16'h1001;
        ctrl(CTRL_PALRT_EN, 1);
        chk("palert", palert_n, 0);
        pwr <= 16'h1000;
        tick(2);
        chk("palert_off", palert_n, 1);
    endtask
    task automatic t_split_regs;
        ctrl(CTRL_SPLIT, 1);
        core <= 8'h80;
        tick(3);
        chk("l2_first", {l2a, l2b, pins[7]}, 3'b101);
        core <= 8'h40;
        tick(3);
        chk("l2_second", {l2a, l2b}, 2'b01);
        apb(0, 8'h20, 0);
        chk("unmapped", d, READ_ZERO);
        apb(0, ADDR_PWR_MEAS, 0);
        chk("pwr_meas", d, 32'h0000_1000);
    endtask
    task automatic summarize;
        $display("tests %0d fail %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        tick(12);
        presetn <= 1;
        tick(3);
        t_reset_offset();
        t_enable();
        t_guard_power();
        t_split_regs();
        summarize();
    end
    initial begin
        tick(3000);
        n_fail++;
        summarize();
    end
endmodule
